// ===== hw/bmd_decoder.sv
/*
 Banked memory map decoder: program counter folding and vectors, data
 bank decoding, mirrored core registers, indirect access, shared RAM.
 Assumes the core presents one data access per cycle and takes read
 data one cycle after the request.
*/
`timescale 1ns/100ps
module bmd_decoder
#(
    parameter bmd_pkg::bmd_variant_type VARIANT = bmd_pkg::BMD_LARGE
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pc_load,
    input wire logic [12:0] pc_load_value,
    input wire logic pc_step,
    input wire logic int_accept,
    output logic [12:0] pc_fetch_addr,
    output logic [12:0] pm_addr,
    input wire logic [13:0] pm_data,
    output logic [13:0] instr_word,
    input wire logic d_rd,
    input wire logic d_wr,
    input wire logic [6:0] d_offset,
    input wire logic [7:0] d_wr_data,
    output logic [7:0] d_rd_data,
    output logic d_rd_valid,
    output logic [1:0] bank_sel,
    output logic [7:0] file_select_pointer,
    output logic [7:0] interrupt_control
);
    logic [12:0] pc_r;
    logic [12:0] pc_nxt;
    logic [7:0] status_r;
    logic [7:0] fsr_r;
    logic [4:0] program_counter_high_latch_r;
    logic [7:0] interrupt_control_r;
    logic [8:0] eff_addr;
    logic [8:0] ram_addr;
    logic ram_hit;
    logic ram_wr;
    logic [7:0] ram_q;
    logic sel_ram_r;
    logic [7:0] reg_q_r;

    // Fold program address to implemented space
    function automatic logic [12:0] fold_pc(input logic [12:0] a);
        case (VARIANT)
            bmd_pkg::BMD_SMALL: fold_pc = a & bmd_pkg::PC_TOP_SMALL;
            bmd_pkg::BMD_MEDIUM: fold_pc = a & bmd_pkg::PC_TOP_MEDIUM;
            default: fold_pc = a & bmd_pkg::PC_TOP_LARGE;
        endcase
    endfunction

    // Map bank and offset to RAM index, flag if implemented
    function automatic logic [9:0] map_ram(input logic [8:0] a);
        logic [6:0] o;
        logic [1:0] b;
        logic hit;
        logic [8:0] idx;
        o = a[6:0];
        b = a[8:7];
        hit = 1'b0;
        idx = a;
        if (o >= bmd_pkg::OFS_SHARED_BASE)
        begin
            hit = 1'b1;
            idx = {2'b00, o};
        end
        else if (o >= bmd_pkg::OFS_GPR_BASE)
        begin
            case (b)
                2'd0: hit = 1'b1;
                2'd1: hit = (VARIANT != bmd_pkg::BMD_SMALL)
                    || (o <= bmd_pkg::OFS_BANK1_GPR_TOP_SMALL);
                2'd2: hit = (VARIANT == bmd_pkg::BMD_LARGE)
                    || ((VARIANT == bmd_pkg::BMD_MEDIUM)
                    && (o <= bmd_pkg::OFS_BANK2_GPR_TOP));
                default: hit = (VARIANT == bmd_pkg::BMD_LARGE);
            endcase
        end
        map_ram = {hit, idx};
    endfunction

    // Next program counter
    always_comb
    begin
        pc_nxt = pc_r;
        if (int_accept)
        begin
            pc_nxt = bmd_pkg::INT_VECTOR;
        end
        else if (d_wr && (eff_addr[6:0] == bmd_pkg::OFS_PC_LOW))
        begin
            pc_nxt = {program_counter_high_latch_r, d_wr_data};
        end
        else if (pc_load)
        begin
            pc_nxt = pc_load_value;
        end
        else if (pc_step)
        begin
            pc_nxt = pc_r + 13'h0001;
        end
    end

    // Program counter register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pc_r <= bmd_pkg::RESET_VECTOR;
        end
        else
        begin
            pc_r <= pc_nxt; // full counter, folded only at decode
        end
    end

    assign pc_fetch_addr = pc_r;
    assign pm_addr = fold_pc(pc_r);

    // Fetched instruction register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            instr_word <= '0;
        end
        else
        begin
            instr_word <= pm_data;
        end
    end

    // Effective data address, direct or through pointer
    always_comb
    begin
        if (d_offset == bmd_pkg::OFS_INDIRECT)
        begin
            eff_addr = {status_r[bmd_pkg::STATUS_IRP_BIT], fsr_r};
        end
        else
        begin
            eff_addr = {bank_sel, d_offset};
        end
    end

    assign bank_sel = {status_r[bmd_pkg::STATUS_BANK_HIGH_BIT],
        status_r[bmd_pkg::STATUS_BANK_LOW_BIT]};
    assign {ram_hit, ram_addr} = map_ram(eff_addr);
    assign ram_wr = d_wr && ram_hit;

    // Mirrored core registers, same in every bank
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            status_r <= bmd_pkg::STATUS_RESET;
            fsr_r <= bmd_pkg::ZERO_BYTE;
            program_counter_high_latch_r <= bmd_pkg::PC_HIGH_RESET;
            interrupt_control_r <= bmd_pkg::ZERO_BYTE;
        end
        else if (d_wr)
        begin
            case (eff_addr[6:0])
                bmd_pkg::OFS_STATUS: status_r <= d_wr_data;
                bmd_pkg::OFS_FSR: fsr_r <= d_wr_data;
                bmd_pkg::OFS_PC_HIGH_LATCH: program_counter_high_latch_r <= d_wr_data[4:0];
                bmd_pkg::OFS_INT_CTRL: interrupt_control_r <= d_wr_data;
                default: ;
            endcase
        end
    end

    // Register read capture
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            reg_q_r <= bmd_pkg::ZERO_BYTE;
            sel_ram_r <= 1'b0;
            d_rd_valid <= 1'b0;
        end
        else
        begin
            d_rd_valid <= d_rd;
            sel_ram_r <= ram_hit;
            case (eff_addr[6:0])
                bmd_pkg::OFS_PC_LOW: reg_q_r <= pc_r[7:0];
                bmd_pkg::OFS_STATUS: reg_q_r <= status_r;
                bmd_pkg::OFS_FSR: reg_q_r <= fsr_r;
                bmd_pkg::OFS_PC_HIGH_LATCH: reg_q_r <= {3'b000, program_counter_high_latch_r};
                bmd_pkg::OFS_INT_CTRL: reg_q_r <= interrupt_control_r;
                default: reg_q_r <= bmd_pkg::ZERO_BYTE;
            endcase
        end
    end

    assign d_rd_data = sel_ram_r ? ram_q : reg_q_r;
    assign file_select_pointer = fsr_r;
    assign interrupt_control = interrupt_control_r;

    bmd_ram u_ram
    (
        .clk_sys(clk_sys),
        .wr_en(ram_wr),
        .addr(ram_addr),
        .wr_data(d_wr_data),
        .rd_data(ram_q)
    );

    // Interrupt entry lands on the vector next cycle
    property p_int_vector;
        @(posedge clk_sys) disable iff (sys_rst)
        int_accept |=> (pc_r == bmd_pkg::INT_VECTOR);
    endproperty
    a_int_vector: assert property (p_int_vector) else $error("pc not at vector");

    // Small variant never exceeds 2K
    property p_fold;
        @(posedge clk_sys) disable iff (sys_rst)
        (VARIANT == bmd_pkg::BMD_SMALL) |-> (pm_addr[12:11] == 2'b00);
    endproperty
    a_fold: assert property (p_fold) else $error("pm address not folded");

    // Pointer write lands in the pointer register next cycle
    property p_ptr_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (d_wr && eff_addr[6:0] == bmd_pkg::OFS_FSR) |=> (fsr_r == $past(d_wr_data));
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("pointer not written");

    // Unimplemented register offset 1Fh reads zero
    property p_unimpl_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        (d_rd && !ram_hit && eff_addr[6:0] == 7'h1f) |=> (d_rd_data == 8'h00);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimpl not zero");

    // Shared window maps to bank 0
    property p_shared;
        @(posedge clk_sys) disable iff (sys_rst)
        (eff_addr[6:0] >= bmd_pkg::OFS_SHARED_BASE) |-> (ram_hit && ram_addr[8:7] == 2'b00);
    endproperty
    a_shared: assert property (p_shared) else $error("shared map wrong");

    // Read valid follows request by one cycle
    property p_rd_valid;
        @(posedge clk_sys) disable iff (sys_rst)
        d_rd |=> d_rd_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid late");

    // Direct address carries the bank bits
    property p_bank;
        @(posedge clk_sys) disable iff (sys_rst)
        (d_offset != bmd_pkg::OFS_INDIRECT) |-> (eff_addr[8:7] == bank_sel);
    endproperty
    a_bank: assert property (p_bank) else $error("bank bits wrong");

    // Offsets below 20h never reach RAM
    property p_sfr_region;
        @(posedge clk_sys) disable iff (sys_rst)
        (eff_addr[6:0] < bmd_pkg::OFS_GPR_BASE) |-> !ram_hit;
    endproperty
    a_sfr_region: assert property (p_sfr_region) else $error("sfr hit ram");

    // Reset puts the counter on the reset vector
    property p_pc_reset;
        @(posedge clk_sys)
        sys_rst |=> (pc_r == bmd_pkg::RESET_VECTOR);
    endproperty
    a_pc_reset: assert property (p_pc_reset) else $error("pc not at reset vector");

    // Low byte write loads latch and data together
    property p_pc_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (d_wr && !int_accept && eff_addr[6:0] == bmd_pkg::OFS_PC_LOW)
            |=> (pc_r == {$past(program_counter_high_latch_r), $past(d_wr_data)});
    endproperty
    a_pc_write: assert property (p_pc_write) else $error("pc low write not loaded");

    // Plain step adds one to the counter
    property p_pc_step;
        @(posedge clk_sys) disable iff (sys_rst)
        (pc_step && !pc_load && !int_accept && !d_wr) |=> (pc_r == $past(pc_r) + 13'h0001);
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc step wrong");

    // Medium store never drives the top fetch bit
    property p_fold_medium;
        @(posedge clk_sys) disable iff (sys_rst)
        (VARIANT == bmd_pkg::BMD_MEDIUM) |-> (pm_addr[12] == 1'b0);
    endproperty
    a_fold_medium: assert property (p_fold_medium) else $error("pm address not folded");

    // Bank 3 has no RAM below the shared window unless large
    property p_bank3_empty;
        @(posedge clk_sys) disable iff (sys_rst)
        (VARIANT != bmd_pkg::BMD_LARGE && eff_addr[8:7] == 2'd3
            && eff_addr[6:0] < bmd_pkg::OFS_SHARED_BASE) |-> !ram_hit;
    endproperty
    a_bank3_empty: assert property (p_bank3_empty) else $error("bank 3 hit ram");
endmodule

// ===== hw/bmd_pkg.sv
/*
 Constants for the banked memory map decoder: program space limits,
 vectors, data bank layout, core register offsets and reset values.
 Assumes a single 125 MHz core clock with a synchronous reset.
*/
package bmd_pkg;
    localparam int PC_W = 13;
    localparam int INSTR_W = 14;
    localparam int DADDR_W = 9;
    localparam int OFS_W = 7;
    localparam int RAM_AW = 9;
    localparam logic [12:0] PC_TOP_SMALL = 13'h07ff;
    localparam logic [12:0] PC_TOP_MEDIUM = 13'h0fff;
    localparam logic [12:0] PC_TOP_LARGE = 13'h1fff;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] INT_VECTOR = 13'h0004;
    localparam logic [6:0] OFS_INDIRECT = 7'h00;
    localparam logic [6:0] OFS_PC_LOW = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_FSR = 7'h04;
    localparam logic [6:0] OFS_PC_HIGH_LATCH = 7'h0a;
    localparam logic [6:0] OFS_INT_CTRL = 7'h0b;
    localparam logic [6:0] OFS_GPR_BASE = 7'h20;
    localparam logic [6:0] OFS_SHARED_BASE = 7'h70;
    localparam logic [6:0] OFS_BANK1_GPR_TOP_SMALL = 7'h3f;
    localparam logic [6:0] OFS_BANK2_GPR_TOP = 7'h2f;
    localparam int STATUS_IRP_BIT = 7;
    localparam int STATUS_BANK_HIGH_BIT = 6;
    localparam int STATUS_BANK_LOW_BIT = 5;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [4:0] PC_HIGH_RESET = 5'h00;
    typedef enum logic [1:0] {BMD_SMALL, BMD_MEDIUM, BMD_LARGE} bmd_variant_type;
endpackage

// ===== hw/bmd_ram.sv
/*
 General purpose RAM store, 512 locations of 8 bits, registered read.
 Assumes the decoder only writes implemented locations.
*/
`timescale 1ns/100ps
module bmd_ram
(
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [8:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:511];

    // Write and registered read
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule

// ===== tb/bmd_core_model.sv
/*
 Core side model: program store answering the fetch address and a
 data access driver. Assumes one access per call, result next cycle.
*/
`timescale 1ns/100ps
module bmd_core_model
(
    input wire logic clk_sys,
    input wire logic [12:0] pm_addr,
    output logic [13:0] pm_data,
    output logic d_rd,
    output logic d_wr,
    output logic [6:0] d_offset,
    output logic [7:0] d_wr_data,
    input wire logic [7:0] d_rd_data,
    input wire logic d_rd_valid
);
    // Store contents follow the address
    assign pm_data = {pm_addr[0], pm_addr} ^ 14'h15a5;
    // Idle request lines
    initial
    begin
        d_rd = 1'b0;
        d_wr = 1'b0;
        d_offset = 7'h55;
        d_wr_data = 8'haa;
    end
    // Request held one edge, result taken at the next falling edge
    task automatic access(input logic wr, input logic [6:0] o, input logic [7:0] wd,
        output logic [7:0] rd, output logic vld);
        @(negedge clk_sys);
        d_rd = !wr;
        d_wr = wr;
        d_offset = o;
        d_wr_data = wd;
        @(negedge clk_sys);
        rd = d_rd_data;
        vld = d_rd_valid;
        d_rd = 1'b0;
        d_wr = 1'b0;
        d_offset = ~o; // Released lines drop the old value
        d_wr_data = ~wd;
    endtask
endmodule

// ===== tb/banked_memory_map_decoder_test.sv
/*
 Testbench for the decoder, medium variant, against an integer map model.
 Assumes the core model drives all data accesses.
*/
`timescale 1ns/100ps
module banked_memory_map_decoder_test;
    logic clk_sys, sys_rst, pc_load, pc_step, int_accept, d_rd, d_wr, d_rd_valid, vld;
    logic [12:0] pc_load_value, pc_fetch_addr, pm_addr, pm_addr_small;
    logic [13:0] pm_data, instr_word;
    logic [6:0] d_offset;
    logic [7:0] d_wr_data, d_rd_data, file_select_pointer, interrupt_control, rd;
    logic [1:0] bank_sel;
    int n_fail = 0;
    int checks_done = 0;
    int seed = 37;
    int m [0:639];
    int bank = 0;
    int irp = 0;
    int k, o, f;
    bmd_decoder #(.VARIANT(bmd_pkg::BMD_MEDIUM)) i_bmd_decoder
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pc_load(pc_load),
        .pc_load_value(pc_load_value),
        .pc_step(pc_step),
        .int_accept(int_accept),
        .pc_fetch_addr(pc_fetch_addr),
        .pm_addr(pm_addr),
        .pm_data(pm_data),
        .instr_word(instr_word),
        .d_rd(d_rd),
        .d_wr(d_wr),
        .d_offset(d_offset),
        .d_wr_data(d_wr_data),
        .d_rd_data(d_rd_data),
        .d_rd_valid(d_rd_valid),
        .bank_sel(bank_sel),
        .file_select_pointer(file_select_pointer),
        .interrupt_control(interrupt_control)
    );
    // Small variant shares the stimulus, only its fold is compared
    bmd_decoder #(.VARIANT(bmd_pkg::BMD_SMALL)) i_bmd_decoder_small
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pc_load(pc_load),
        .pc_load_value(pc_load_value),
        .pc_step(pc_step),
        .int_accept(int_accept),
        .pc_fetch_addr(),
        .pm_addr(pm_addr_small),
        .pm_data(pm_data),
        .instr_word(),
        .d_rd(d_rd),
        .d_wr(d_wr),
        .d_offset(d_offset),
        .d_wr_data(d_wr_data),
        .d_rd_data(),
        .d_rd_valid(),
        .bank_sel(),
        .file_select_pointer(),
        .interrupt_control()
    );
    bmd_core_model i_bmd_core_model
    (
        .clk_sys(clk_sys),
        .pm_addr(pm_addr),
        .pm_data(pm_data),
        .d_rd(d_rd),
        .d_wr(d_wr),
        .d_offset(d_offset),
        .d_wr_data(d_wr_data),
        .d_rd_data(d_rd_data),
        .d_rd_valid(d_rd_valid)
    );
    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Model slot of a data address, -1 where nothing is implemented
    function automatic int loc(input int a);
        int t;
        t = a & 'h7f;
        if (t inside {2, 3, 4, 'h0a, 'h0b})
            return 512 + t;
        if (t >= 'h70)
            return t;
        if (t < 'h20 || a > 'h12f)
            return -1;
        return a;
    endfunction
    // Direct or indirect access checked against the model
    task automatic op(input bit wr, input bit ind, input int ofs, input int d);
        int a;
        a = ind ? irp * 256 + m[516] : bank * 128 + ofs;
        i_bmd_core_model.access(wr, ind ? 7'h00 : 7'(ofs), 8'(d), rd, vld);
        if (wr && loc(a) >= 0)
            m[loc(a)] = d;
        if (!wr)
        begin
            chk("read valid", 1, vld);
            if (loc(a) < 0)
                chk("empty read", 0, rd);
            else if (m[loc(a)] >= 0)
                chk("read data", m[loc(a)], rd);
        end
    endtask
    task automatic set_bank(input int b, input int i);
        op(1, 0, 3, i * 128 + b * 32 + 'h18);
        bank = b;
        irp = i;
        chk("bank select", b, bank_sel);
    endtask
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("unexpected timeout: expected end, seen none");
        final_report;
    end
    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        pc_load = 1'b0;
        pc_step = 1'b0;
        int_accept = 1'b0;
        pc_load_value = 13'h0000;
        foreach (m[i]) m[i] = -1;
        m[515] = 'h18;
        m[516] = 0;
        m[523] = 0;
        repeat (3) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("pc after reset", 0, pc_fetch_addr);
        op(0, 0, 3, 0);
        $display("reset test done");
        pc_step = 1'b1;
        repeat (3) @(negedge clk_sys);
        pc_step = 1'b0;
        @(negedge clk_sys);
        chk("pc step", 3, pc_fetch_addr);
        chk("instr word", 14'h0003 ^ 14'h15a5 ^ 14'h2000, instr_word);
        pc_load_value = 13'h1ffe;
        pc_load = 1'b1;
        @(negedge clk_sys);
        pc_load = 1'b0;
        chk("pc load", 'h1ffe, pc_fetch_addr);
        chk("folded addr", 'h0ffe, pm_addr);
        chk("small fold", 'h07fe, pm_addr_small);
        int_accept = 1'b1;
        pc_step = 1'b1;
        @(negedge clk_sys);
        int_accept = 1'b0;
        pc_step = 1'b0;
        chk("int vector", 'h0004, pc_fetch_addr);
        op(1, 0, 'h0a, 'h1a);
        op(1, 0, 2, 'h34);
        chk("pc write", 'h1a34, pc_fetch_addr);
        chk("folded write", 'h0a34, pm_addr);
        chk("small fold write", 'h0234, pm_addr_small);
        $display("program test done");
        for (int b = 0; b < 4; b++)
        begin
            set_bank(b, 0);
            op(0, 0, 2, 0);
            op(0, 0, 4, 0);
            op(0, 0, 'h0b, 0);
            op(0, 0, 'h35, 0);
            op(0, 0, 'h1f, 0);
        end
        $display("mirror test done");
        repeat (300)
        begin
            k = $random(seed) & 3;
            o = $random(seed) & 'h7f;
            if (o < 4 || o == 'h0a)
                o = o + 'h40;
            f = ($random(seed) & 'hff) | 'h20;
            if (k == 0)
                set_bank($random(seed) & 3, $random(seed) & 1);
            else if (k == 1)
                op($random(seed) & 1, 0, o, $random(seed) & 'hff);
            else
            begin
                op(1, 0, 4, f);
                op($random(seed) & 1, 1, 0, $random(seed) & 'hff);
            end
            chk("pointer", m[516], file_select_pointer);
            chk("int control", m[523], interrupt_control);
        end
        $display("random test done");
        final_report;
    end
endmodule
